// *** hw/pmc_pkg.sv ***
// constants and types of the power mode controller
package pmc_pkg;
  localparam int unsigned AW = 2;
  localparam int unsigned DW = 8;
  // register offsets
  localparam logic [1:0] ADDR_MODE   = 2'h0;
  localparam logic [1:0] ADDR_CTRL   = 2'h1;
  localparam logic [1:0] ADDR_WAKE   = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;
  // mode, control and status register fields
  localparam int unsigned MODE_CKS_LSB = 5;
  localparam int unsigned MODE_LTO     = 3;
  localparam int unsigned MODE_HTO     = 2;
  localparam int unsigned MODE_IDLE_ON_HALT_ENABLE   = 1;
  localparam int unsigned MODE_HIGH_CLOCK_SELECT   = 0;
  localparam int unsigned CTRL_IDLE_SYSCLK_KEEP  = 7;
  localparam int unsigned STAT_TO      = 1;
  localparam int unsigned STAT_PDF     = 0;
  // reset values
  localparam logic [2:0] CKS_RST    = 3'h0;
  localparam logic       IDLE_ON_HALT_ENABLE_RST  = 1'b1;
  localparam logic       HIGH_CLOCK_SELECT_RST  = 1'b1;
  localparam logic       IDLE_SYSCLK_KEEP_RST = 1'b0;
  localparam logic [7:0] WAKE_RST   = 8'h00;
  // divider selects below this pick the sub clock while high clock select is clear
  localparam logic [2:0] CKS_FIRST_DIV = 3'h2;
  localparam logic [3:0] DIV_EXP_BASE  = 4'h8;
  // oscillator settle counts, in oscillator cycles
  localparam logic [4:0] HTO_CYC = 5'h10;
  localparam logic [1:0] LTO_CYC = 2'h2;
  // one-hot operating states
  typedef enum logic [5:0] {
    ST_RUN    = 6'h01,
    ST_SLEEP0 = 6'h02,
    ST_SLEEP1 = 6'h04,
    ST_IDLE0  = 6'h08,
    ST_IDLE1  = 6'h10,
    ST_WAKE   = 6'h20
  } pmc_state_t;
  // register access from software
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } pmc_bus_t;
  // cpu side events
  typedef struct packed {
    logic halt;
    logic clr_wdt;
    logic wdt_on;
    logic lvd_on;
    logic wdt_ovf;
    logic stack_full;
  } pmc_cpu_t;
endpackage

// *** hw/pmc_power_mode_controller.sv ***
// power mode, clock gating and wake-up controller
`timescale 1ns/10ps
module pmc_power_mode_controller
  import pmc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              srst,
  input  wire pmc_pkg::pmc_bus_t bus,
  output logic [7:0]             rdata_ff,
  input  wire pmc_pkg::pmc_cpu_t cpu,
  input  wire logic [7:0]        int_req,
  input  wire logic [7:0]        int_en,
  input  wire logic [7:0]        porta_pin,
  input  wire logic              sub_tick,
  output logic                   cpu_run_ff,
  output logic                   sys_tick_ff,
  output logic                   high_osc_on_ff,
  output logic                   sub_osc_on_ff,
  output logic                   wdt_clear_ff,
  output logic                   wdt_run_ff,
  output logic                   pc_sp_reset_ff,
  output logic                   int_vector_ff,
  output logic                   resume_next_ff,
  output logic [5:0]             mode_ff
);

  pmc_state_t state_ff;
  pmc_state_t nxt_state;
  logic [2:0] clock_divider_select_ff;
  logic       idle_on_halt_enable_ff;
  logic       high_clock_select_ff;
  logic       idle_sysclk_keep_ff;
  logic [7:0] porta_wake_enable_ff;
  logic       power_down_flag_ff;
  logic       watchdog_timeout_flag_ff;
  logic [4:0] hto_cnt_ff;
  logic [1:0] lto_cnt_ff;
  logic       high_osc_stable_flag;
  logic       low_osc_stable_flag;
  logic [7:0] pin_s1_ff;
  logic [7:0] pin_s2_ff;
  logic [7:0] pin_s3_ff;
  logic [7:0] int_pre_ff;
  logic [5:0] div_cnt_ff;
  logic [1:0] cause_ff;
  logic [7:0] int_hit_ff;
  logic       sys_from_sub;
  logic       halted;
  logic       fh_need;
  logic       sub_need;
  logic       pin_wake;
  logic [7:0] int_wake;
  logic       wake;
  logic       osc_ready;
  logic [5:0] div_mask;
  logic [3:0] div_exp;

  // wake cause codes
  localparam logic [1:0] CAUSE_PIN = 2'h0;
  localparam logic [1:0] CAUSE_INT = 2'h1;
  localparam logic [1:0] CAUSE_WDT = 2'h2;

  // slow mode selection from the clock select bits
  assign sys_from_sub = ~high_clock_select_ff &
                        (clock_divider_select_ff < CKS_FIRST_DIV);
  assign halted = (state_ff != ST_RUN) && (state_ff != ST_WAKE);

  // high oscillator runs only when the system clock uses it
  always_comb begin
    fh_need = ~sys_from_sub;
    if (state_ff == ST_SLEEP0 || state_ff == ST_SLEEP1 ||
        state_ff == ST_IDLE0) begin
      fh_need = 1'b0;
    end
  end

  // sub clock stops only in sleep0; the detector forces it on
  assign sub_need = (state_ff != ST_SLEEP0) | cpu.lvd_on;

  // settle counters restart whenever the oscillator is stopped
  always_ff @(posedge clk) begin
    if (srst || !fh_need) begin
      hto_cnt_ff <= 5'h00;
    end else if (hto_cnt_ff != HTO_CYC) begin
      hto_cnt_ff <= hto_cnt_ff + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst || !sub_need) begin
      lto_cnt_ff <= 2'h0;
    end else if (lto_cnt_ff != LTO_CYC && sub_tick) begin
      lto_cnt_ff <= lto_cnt_ff + 2'h1;
    end
  end

  assign high_osc_stable_flag = (hto_cnt_ff == HTO_CYC);
  assign low_osc_stable_flag  = (lto_cnt_ff == LTO_CYC);

  // port pins cross in through two flops, third flop for the edge
  always_ff @(posedge clk) begin
    if (srst) begin
      pin_s1_ff <= 8'hFF;
      pin_s2_ff <= 8'hFF;
      pin_s3_ff <= 8'hFF;
    end else begin
      pin_s1_ff <= porta_pin;
      pin_s2_ff <= pin_s1_ff;
      pin_s3_ff <= pin_s2_ff;
    end
  end

  // per pin falling edge gated by its own enable bit
  assign pin_wake = |(pin_s3_ff & ~pin_s2_ff &
                      porta_wake_enable_ff);
  // requests pending at halt are masked out as wake sources
  assign int_wake = int_req & ~int_pre_ff;
  assign wake = pin_wake | (|int_wake) | cpu.wdt_ovf;

  // cpu restarts only once the chosen clock source is stable
  assign osc_ready = sys_from_sub ? low_osc_stable_flag
                                  : high_osc_stable_flag;

  // operating state machine
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_RUN: begin
        if (cpu.halt) begin
          if (idle_on_halt_enable_ff) begin
            nxt_state = idle_sysclk_keep_ff ? ST_IDLE1
                                            : ST_IDLE0;
          end else if (cpu.wdt_on || cpu.lvd_on) begin
            nxt_state = ST_SLEEP1;
          end else begin
            nxt_state = ST_SLEEP0;
          end
        end
      end
      ST_SLEEP0, ST_SLEEP1, ST_IDLE0, ST_IDLE1: begin
        if (wake) begin
          nxt_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (osc_ready) begin
          nxt_state = ST_RUN;
        end
      end
      default: begin
        nxt_state = ST_RUN;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_ff <= ST_RUN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // snapshot of pending requests taken as the halt is accepted
  always_ff @(posedge clk) begin
    if (srst) begin
      int_pre_ff <= 8'h00;
    end else if (state_ff == ST_RUN && cpu.halt) begin
      int_pre_ff <= int_req;
    end
  end

  // remember why we woke; watchdog outranks interrupt outranks pin
  always_ff @(posedge clk) begin
    if (srst) begin
      cause_ff   <= CAUSE_PIN;
      int_hit_ff <= 8'h00;
    end else if (halted && wake) begin
      int_hit_ff <= int_wake;
      if (cpu.wdt_ovf) begin
        cause_ff <= CAUSE_WDT;
      end else if (|int_wake) begin
        cause_ff <= CAUSE_INT;
      end else begin
        cause_ff <= CAUSE_PIN;
      end
    end
  end

  // resume actions, one pulse each as the cpu restarts
  always_ff @(posedge clk) begin
    if (srst) begin
      pc_sp_reset_ff <= 1'b0;
      int_vector_ff  <= 1'b0;
      resume_next_ff <= 1'b0;
    end else begin
      pc_sp_reset_ff <= 1'b0;
      int_vector_ff  <= 1'b0;
      resume_next_ff <= 1'b0;
      if (state_ff == ST_WAKE && osc_ready) begin
        if (cause_ff == CAUSE_WDT) begin
          pc_sp_reset_ff <= 1'b1;
        end else if (cause_ff == CAUSE_INT &&
                     |(int_hit_ff & int_en) && !cpu.stack_full) begin
          int_vector_ff <= 1'b1;
        end else begin
          // request left pending in its flag for later service
          resume_next_ff <= 1'b1;
        end
      end
    end
  end

  // watchdog clear on every halt; it runs on in all but sleep0
  always_ff @(posedge clk) begin
    if (srst) begin
      wdt_clear_ff <= 1'b0;
      wdt_run_ff   <= 1'b0;
    end else begin
      wdt_clear_ff <= (state_ff == ST_RUN) && cpu.halt;
      wdt_run_ff   <= cpu.wdt_on &&
                      (nxt_state != ST_SLEEP0);
    end
  end

  // power-down flag: set on halt wins over clear-watchdog
  always_ff @(posedge clk) begin
    if (srst) begin
      power_down_flag_ff <= 1'b0;
    end else if (state_ff == ST_RUN && cpu.halt) begin
      power_down_flag_ff <= 1'b1;
    end else if (cpu.clr_wdt) begin
      power_down_flag_ff <= 1'b0;
    end
  end

  // timeout flag set by watchdog wake, cleared by halt
  always_ff @(posedge clk) begin
    if (srst) begin
      watchdog_timeout_flag_ff <= 1'b0;
    end else if (halted && cpu.wdt_ovf) begin
      watchdog_timeout_flag_ff <= 1'b1;
    end else if (state_ff == ST_RUN && cpu.halt) begin
      watchdog_timeout_flag_ff <= 1'b0;
    end
  end

  // control registers; writes only land in the run and wake states
  always_ff @(posedge clk) begin
    if (srst) begin
      clock_divider_select_ff <= CKS_RST;
      idle_on_halt_enable_ff  <= IDLE_ON_HALT_ENABLE_RST;
      high_clock_select_ff    <= HIGH_CLOCK_SELECT_RST;
      idle_sysclk_keep_ff     <= IDLE_SYSCLK_KEEP_RST;
      porta_wake_enable_ff    <= WAKE_RST;
    end else if (bus.wr && !halted) begin
      case (bus.addr)
        ADDR_MODE: begin
          clock_divider_select_ff <= bus.wdata[MODE_CKS_LSB +: 3];
          idle_on_halt_enable_ff  <= bus.wdata[MODE_IDLE_ON_HALT_ENABLE];
          high_clock_select_ff    <= bus.wdata[MODE_HIGH_CLOCK_SELECT];
        end
        ADDR_CTRL: begin
          idle_sysclk_keep_ff <= bus.wdata[CTRL_IDLE_SYSCLK_KEEP];
        end
        ADDR_WAKE: begin
          porta_wake_enable_ff <= bus.wdata;
        end
        default: begin
        end
      endcase
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk) begin
    if (srst) begin
      rdata_ff <= 8'h00;
    end else if (bus.rd) begin
      case (bus.addr)
        ADDR_MODE: begin
          rdata_ff <= {clock_divider_select_ff, 1'b0,
                       low_osc_stable_flag, high_osc_stable_flag,
                       idle_on_halt_enable_ff, high_clock_select_ff};
        end
        ADDR_CTRL: begin
          rdata_ff <= {idle_sysclk_keep_ff, 7'h00};
        end
        ADDR_WAKE: begin
          rdata_ff <= porta_wake_enable_ff;
        end
        default: begin
          rdata_ff <= {6'h00, watchdog_timeout_flag_ff,
                       power_down_flag_ff};
        end
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  // divide ratio 2^(8-sel): 010 gives 64 down to 111 giving 2
  assign div_exp  = DIV_EXP_BASE - {1'b0, clock_divider_select_ff};
  assign div_mask = 6'((7'h01 << div_exp) - 7'h01);

  // divider runs only while the high clock is needed
  always_ff @(posedge clk) begin
    if (srst || !fh_need) begin
      div_cnt_ff <= 6'h00;
    end else begin
      div_cnt_ff <= div_cnt_ff + 6'h01;
    end
  end

  // system clock enable; stopped in sleep and idle0, kept in idle1
  always_ff @(posedge clk) begin
    if (srst) begin
      sys_tick_ff <= 1'b0;
    end else if (state_ff == ST_SLEEP0 || state_ff == ST_SLEEP1 ||
                 state_ff == ST_IDLE0) begin
      sys_tick_ff <= 1'b0;
    end else if (sys_from_sub) begin
      sys_tick_ff <= sub_tick;
    end else if (high_clock_select_ff) begin
      sys_tick_ff <= 1'b1;
    end else begin
      sys_tick_ff <= (div_cnt_ff & div_mask) == div_mask;
    end
  end

  // clock gates and cpu enable; a halted cpu freezes all state
  always_ff @(posedge clk) begin
    if (srst) begin
      cpu_run_ff     <= 1'b1;
      high_osc_on_ff <= 1'b1;
      sub_osc_on_ff  <= 1'b1;
      mode_ff        <= ST_RUN;
    end else begin
      cpu_run_ff     <= (nxt_state == ST_RUN);
      high_osc_on_ff <= fh_need;
      sub_osc_on_ff  <= sub_need;
      mode_ff        <= nxt_state;
    end
  end

endmodule

// *** testbench/pmc_power_mode_controller_properties.sv ***
// port checker for the power mode controller
`timescale 1ns/10ps
module pmc_checker
  import pmc_pkg::*;
(
  input wire logic              clk,
  input wire logic              srst,
  input wire pmc_pkg::pmc_bus_t bus,
  input wire logic [7:0]        rdata_ff,
  input wire pmc_pkg::pmc_cpu_t cpu,
  input wire logic [7:0]        int_req,
  input wire logic [7:0]        int_en,
  input wire logic [7:0]        porta_pin,
  input wire logic              sub_tick,
  input wire logic              cpu_run_ff,
  input wire logic              sys_tick_ff,
  input wire logic              high_osc_on_ff,
  input wire logic              sub_osc_on_ff,
  input wire logic              wdt_clear_ff,
  input wire logic              wdt_run_ff,
  input wire logic              pc_sp_reset_ff,
  input wire logic              int_vector_ff,
  input wire logic              resume_next_ff,
  input wire logic [5:0]        mode_ff
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);
  // halt accepted, watchdog wake and start of waking
  sequence s_halt;
    cpu.halt && mode_ff == ST_RUN;
  endsequence
  sequence s_wdt_wake;
    cpu.wdt_ovf && !(mode_ff inside {ST_RUN, ST_WAKE});
  endsequence
  sequence s_wake_start;
    $rose(mode_ff == ST_WAKE);
  endsequence
  property p_halt_stop;
    s_halt |=> !cpu_run_ff && wdt_clear_ff && mode_ff != ST_RUN;
  endproperty
  a_halt_stop: assert property (p_halt_stop)
    else $error("halt did not stop the cpu");
  property p_sleep_kind;
    s_halt ##0 (cpu.wdt_on || cpu.lvd_on) |=> mode_ff != ST_SLEEP0;
  endproperty
  a_sleep_kind: assert property (p_sleep_kind)
    else $error("sleep0 entered with watchdog or detector on");
  // settled states only, outputs may trail the state by a cycle
  property p_sleep0_off;
    $past(mode_ff) == ST_SLEEP0 && mode_ff == ST_SLEEP0
      |-> !sub_osc_on_ff && !high_osc_on_ff && !wdt_run_ff;
  endproperty
  a_sleep0_off: assert property (p_sleep0_off)
    else $error("clock or watchdog running in sleep0");
  property p_sub_keep;
    $past(mode_ff) == mode_ff
      && mode_ff inside {ST_SLEEP1, ST_IDLE0, ST_IDLE1}
      |-> sub_osc_on_ff && !cpu_run_ff;
  endproperty
  a_sub_keep: assert property (p_sub_keep)
    else $error("sub clock off or cpu running while halted");
  property p_idle0_stop;
    $past(mode_ff) == ST_IDLE0 && mode_ff == ST_IDLE0
      |-> !high_osc_on_ff && !sys_tick_ff;
  endproperty
  a_idle0_stop: assert property (p_idle0_stop)
    else $error("system clock running in idle0");
  property p_wdt_wake;
    s_wdt_wake |=> mode_ff == ST_WAKE;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake)
    else $error("watchdog overflow did not wake");
  property p_wake_hold;
    mode_ff == ST_WAKE |-> !cpu_run_ff;
  endproperty
  a_wake_hold: assert property (p_wake_hold)
    else $error("cpu ran before the oscillator settled");
  property p_wake_done;
    s_wake_start |-> ##[1:64] mode_ff == ST_RUN;
  endproperty
  a_wake_done: assert property (p_wake_done)
    else $error("wake-up did not finish in time");
  property p_restart;
    $rose(cpu_run_ff)
      |-> $onehot({pc_sp_reset_ff, int_vector_ff, resume_next_ff});
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart kind not one-hot");
endmodule

bind pmc_power_mode_controller pmc_checker u_chk (.clk, .srst, .bus,
  .rdata_ff, .cpu, .int_req, .int_en, .porta_pin, .sub_tick, .cpu_run_ff,
  .sys_tick_ff, .high_osc_on_ff, .sub_osc_on_ff, .wdt_clear_ff,
  .wdt_run_ff, .pc_sp_reset_ff, .int_vector_ff, .resume_next_ff, .mode_ff);

// *** testbench/pmc_power_mode_controller_tb.sv ***
// self-checking bench for the power mode controller
`timescale 1ns/10ps
module pmc_power_mode_controller_tb;
  import pmc_pkg::*;
  typedef struct packed {
    logic [7:0] smode;
    logic [7:0] ctrl;
    logic       wd;
    logic       lv;
    logic [1:0] cause;
    logic [5:0] md;
  } pmc_row_t;
  logic       clk, srst;
  logic       sub_tick = 1'b0;
  pmc_bus_t   bus;
  pmc_cpu_t   cpu;
  logic [7:0] int_req, int_en, porta_pin, rdata_ff;
  logic       cpu_run_ff, sys_tick_ff, high_osc_on_ff, sub_osc_on_ff;
  logic       wdt_clear_ff, wdt_run_ff, pc_sp_reset_ff, int_vector_ff;
  logic       resume_next_ff;
  logic [5:0] mode_ff;
  logic [2:0] seen;
  logic [1:0] sdiv = 2'h0;
  logic [7:0] want;
  int         failures, total_checks, n, k;
  pmc_row_t   rows [5];

  pmc_power_mode_controller u_dut (.clk, .srst, .bus, .rdata_ff, .cpu,
    .int_req, .int_en, .porta_pin, .sub_tick, .cpu_run_ff, .sys_tick_ff,
    .high_osc_on_ff, .sub_osc_on_ff, .wdt_clear_ff, .wdt_run_ff,
    .pc_sp_reset_ff, .int_vector_ff, .resume_next_ff, .mode_ff);

  // 250 MHz clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // slow oscillator tick every fourth cycle, so slow mode is visible
  always @(posedge clk) begin
    sdiv <= sdiv + 2'h1;
    sub_tick <= (sdiv == 2'h3);
  end

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // register bus: one-cycle strobes, read data only in the next cycle
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk); // fresh edge, so back-to-back calls never meet
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] m,
                    input logic [7:0] e, input string nm);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 chk(nm, e, rdata_ff & m);
  endtask

  task automatic halt(input logic [5:0] e);
    @(posedge clk);
    cpu.halt <= 1'b1;
    @(posedge clk);
    cpu.halt <= 1'b0;
    #1 chk("mode", {2'h0, e}, {2'h0, mode_ff});
    chk("wdt_clear", 8'h01, {7'h0, wdt_clear_ff});
  endtask

  // waits for the cpu to restart and gathers the restart pulses
  task automatic waitrun();
    seen = 3'h0;
    n = 0;
    while (cpu_run_ff !== 1'b1 && n < 300) begin
      @(posedge clk);
      #1;
      n++;
      seen |= {pc_sp_reset_ff, int_vector_ff, resume_next_ff};
    end
    chk("cpu_run", 8'h01, {7'h0, cpu_run_ff});
  endtask

  // raise one wake source, then let the sources go idle again
  task automatic wake(input logic [1:0] c);
    case (c)
      2'h0: cpu.wdt_ovf <= 1'b1;
      2'h1: int_en <= 8'h01;
      default: int_en <= 8'h00;
    endcase
    if (c inside {2'h1, 2'h2})
      int_req <= 8'h01;
    if (c == 2'h3)
      porta_pin <= 8'hFE;
    @(posedge clk);
    cpu.wdt_ovf <= 1'b0;
    waitrun();
    int_req <= 8'h00;
    int_en <= 8'h00;
    porta_pin <= 8'hFF;
  endtask

  // sys ticks over 128 cycles, after the divider has settled
  task automatic ticks(input logic [7:0] e);
    repeat (128) @(posedge clk);
    n = 0;
    repeat (128) begin
      @(posedge clk);
      #1 if (sys_tick_ff === 1'b1) n++;
    end
    chk("sys_ticks", e, 8'(n));
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // hang guard, generous against roughly 2400 cycles of tests
  initial begin
    #80000;
    failures++;
    $display("MISMATCH watchdog expected done seen timeout");
    close_out();
  end

  initial begin
    srst = 1'b1;
    bus = '0;
    cpu = '0;
    int_req = 8'h00;
    int_en = 8'h00;
    porta_pin = 8'hFF;
    failures = 0;
    total_checks = 0;
    rows = '{'{8'h01, 8'h00, 1'b0, 1'b0, 2'h3, ST_SLEEP0},
             '{8'h01, 8'h00, 1'b1, 1'b0, 2'h0, ST_SLEEP1},
             '{8'h01, 8'h00, 1'b0, 1'b1, 2'h1, ST_SLEEP1},
             '{8'h03, 8'h00, 1'b0, 1'b0, 2'h2, ST_IDLE0},
             '{8'h03, 8'h80, 1'b1, 1'b0, 2'h0, ST_IDLE1}};
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    repeat (20) @(posedge clk);
    rd(ADDR_MODE, 8'hF7, 8'h07, "mode");
    wr(ADDR_STATUS, 8'h03);
    rd(ADDR_STATUS, 8'hFF, 8'h00, "status");
    $display("reset test done");
    // halt targets and wake causes; a watchdog wake leaves the timeout
    // flag set, so the following halt must clear it
    foreach (rows[i]) begin
      wr(ADDR_MODE, rows[i].smode);
      wr(ADDR_CTRL, rows[i].ctrl);
      wr(ADDR_WAKE, 8'h01);
      cpu.wdt_on <= rows[i].wd;
      cpu.lvd_on <= rows[i].lv;
      halt(rows[i].md);
      chk("wdt_run", {7'h0, rows[i].wd}, {7'h0, wdt_run_ff});
      rd(ADDR_STATUS, 8'h03, 8'h01, "status");
      wake(rows[i].cause);
      want = (rows[i].cause == 2'h0) ? 8'h04 :
             (rows[i].cause == 2'h1) ? 8'h02 : 8'h01;
      chk("restart", want, {5'h0, seen});
      if (rows[i].md != ST_IDLE1)
        chk("settle", 8'h01, {7'h0, n >= 15});
      want = {6'h0, rows[i].cause == 2'h0, 1'b1};
      rd(ADDR_STATUS, 8'h03, want, "st");
      cpu.clr_wdt <= 1'b1;
      @(posedge clk);
      cpu.clr_wdt <= 1'b0;
      rd(ADDR_STATUS, 8'h01, 8'h00, "pdf");
      $display("row %0d done", i);
    end
    cpu.wdt_on <= 1'b0;
    cpu.lvd_on <= 1'b0;
    // old request must not wake; full stack resumes after the halt
    int_en <= 8'h01;
    int_req <= 8'h02;
    halt(ST_IDLE1);
    wr(ADDR_MODE, 8'h00);
    repeat (20) @(posedge clk);
    #1 chk("pending", {2'h0, ST_IDLE1}, {2'h0, mode_ff});
    cpu.stack_full <= 1'b1;
    int_req <= 8'h03;
    waitrun();
    chk("restart", 8'h01, {5'h0, seen});
    rd(ADDR_MODE, 8'hF3, 8'h03, "hold");
    int_req <= 8'h00;
    int_en <= 8'h00;
    cpu.stack_full <= 1'b0;
    $display("pending test done");
    // only the enabled pin may wake
    wr(ADDR_WAKE, 8'h02);
    halt(ST_IDLE1);
    porta_pin <= 8'hFE;
    repeat (20) @(posedge clk);
    #1 chk("pin0", {2'h0, ST_IDLE1}, {2'h0, mode_ff});
    porta_pin <= 8'hFC;
    waitrun();
    chk("restart", 8'h01, {5'h0, seen});
    porta_pin <= 8'hFF;
    $display("pin test done");
    // slow mode, then every divider, then full speed
    wr(ADDR_MODE, 8'h02);
    repeat (64) @(posedge clk);
    #1 chk("high_osc", 8'h00, {7'h0, high_osc_on_ff});
    rd(ADDR_MODE, 8'h08, 8'h08, "lto");
    ticks(8'd32);
    for (k = 2; k < 8; k++) begin
      wr(ADDR_MODE, {k[2:0], 5'h02});
      ticks(8'(128 >> (8 - k)));
    end
    wr(ADDR_MODE, 8'h03);
    ticks(8'd128);
    rd(ADDR_MODE, 8'h04, 8'h04, "hto");
    $display("clock test done");
    // reset in mid-halt clears the power-down flag
    halt(ST_IDLE1);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    #1 chk("mode", {2'h0, ST_RUN}, {2'h0, mode_ff});
    rd(ADDR_STATUS, 8'h03, 8'h00, "pdf");
    $display("reset test done");
    close_out();
  end
endmodule
